// ---- rtl/mde_pkg.sv ----
// Register map, field positions, init values and tables of the digest engine
package mde_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FIN = 8'h04;
    localparam logic [7:0] OFS_DIN = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_DIG0 = 8'h14;
    localparam int CTL_INIT = 0;
    localparam int CTL_ALGO = 1;
    localparam int CTL_HMAC = 2;
    localparam int CTL_SWAP = 3;
    localparam int CTL_DMA = 5;
    localparam int FIN_GO = 8;
    localparam int STS_INRDY = 0;
    localparam int STS_DONE = 1;
    localparam int STS_DMA = 2;
    localparam int STS_BUSY = 3;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [6:0] SHA1_BLOCK_CYC = 7'h42;
    localparam logic [6:0] MD5_BLOCK_CYC = 7'h32;
    localparam logic [6:0] SHA1_ROUNDS = 7'h50;
    localparam logic [6:0] MD5_ROUNDS = 7'h40;
    localparam int BLK_WORDS = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int DIG_WORDS = 5;
    localparam logic [31:0] IPAD = 32'h36363636;
    localparam logic [31:0] OPAD = 32'h5C5C5C5C;
    localparam logic [31:0] H_INIT [5] = '{32'h67452301, 32'hEFCDAB89, 32'h98BADCFE,
        32'h10325476, 32'hC3D2E1F0};
    localparam logic [31:0] SHA_K [4] = '{32'h5A827999, 32'h6ED9EBA1, 32'h8F1BBCDC,
        32'hCA62C1D6};
    localparam logic [4:0] MD5_S [16] = '{5'h07, 5'h0C, 5'h11, 5'h16, 5'h05, 5'h09,
        5'h0E, 5'h14, 5'h04, 5'h0B, 5'h10, 5'h17, 5'h06, 5'h0A, 5'h0F, 5'h15};
    localparam logic [31:0] MD5_K [64] = '{
        32'hD76AA478, 32'hE8C7B756, 32'h242070DB, 32'hC1BDCEEE, 32'hF57C0FAF, 32'h4787C62A,
        32'hA8304613, 32'hFD469501, 32'h698098D8, 32'h8B44F7AF, 32'hFFFF5BB1, 32'h895CD7BE,
        32'h6B901122, 32'hFD987193, 32'hA679438E, 32'h49B40821, 32'hF61E2562, 32'hC040B340,
        32'h265E5A51, 32'hE9B6C7AA, 32'hD62F105D, 32'h02441453, 32'hD8A1E681, 32'hE7D3FBC8,
        32'h21E1CDE6, 32'hC33707D6, 32'hF4D50D87, 32'h455A14ED, 32'hA9E3E905, 32'hFCEFA3F8,
        32'h676F02D9, 32'h8D2A4C8A, 32'hFFFA3942, 32'h8771F681, 32'h6D9D6122, 32'hFDE5380C,
        32'hA4BEEA44, 32'h4BDECFA9, 32'hF6BB4B60, 32'hBEBFBC70, 32'h289B7EC6, 32'hEAA127FA,
        32'hD4EF3085, 32'h04881D05, 32'hD9D4D039, 32'hE6DB99E5, 32'h1FA27CF8, 32'hC4AC5665,
        32'hF4292244, 32'h432AFF97, 32'hAB9423A7, 32'hFC93A039, 32'h655B59C3, 32'h8F0CCC92,
        32'hFFEFF47D, 32'h85845DD1, 32'h6FA87E4F, 32'hFE2CE6E0, 32'hA3014314, 32'h4E0811A1,
        32'hF7537E82, 32'hBD3AF235, 32'h2AD7D2BB, 32'hEB86D391};
    typedef enum logic [1:0] {MDE_SW_WORD, MDE_SW_HALF, MDE_SW_BYTE, MDE_SW_BIT} mde_swap_t;
    typedef enum logic [2:0] {PH_IDLE, PH_KEY_IN, PH_MSG, PH_KEY_OUT, PH_INNER, PH_TAIL,
        PH_DONE} mde_phase_t;
    typedef enum logic {CORE_IDLE, CORE_RUN} mde_core_t;
endpackage

// ---- rtl/mde_step_if.sv ----
// One compression step: working state in and out, message word, round index
`timescale 1ns/1ps
interface mde_step_if;
    logic [4:0][31:0] wk_in;
    logic [4:0][31:0] wk_out;
    logic [31:0] wrd;
    logic [6:0] rnd;
    logic md5;
    modport core (output wk_in, wrd, rnd, md5, input wk_out);
    modport step (input wk_in, wrd, rnd, md5, output wk_out);
endinterface

// ---- rtl/mde_step.sv ----
// Combinational SHA-1 or MD5 round step
`timescale 1ns/1ps
module mde_step (
    mde_step_if.step sif
);
    logic [31:0] a, b, c, d, e, f, sum;
    logic [63:0] dbl;
    logic [1:0] kx;
    always_comb begin
        a = sif.wk_in[0];
        b = sif.wk_in[1];
        c = sif.wk_in[2];
        d = sif.wk_in[3];
        e = sif.wk_in[4];
        f = '0;
        kx = 2'h0;
        dbl = '0;
        if (sif.md5) begin
            unique case (sif.rnd[5:4])
                2'h0: f = (b & c) | (~b & d);
                2'h1: f = (d & b) | (~d & c);
                2'h2: f = b ^ c ^ d;
                2'h3: f = c ^ (b | ~d);
            endcase
            sum = a + f + mde_pkg::MD5_K[sif.rnd[5:0]] + sif.wrd;
            dbl = {sum, sum} << mde_pkg::MD5_S[{sif.rnd[5:4], sif.rnd[1:0]}];
            sif.wk_out = {e, c, b, b + dbl[63:32], d};
        end else begin
            if (sif.rnd < 7'h14) begin
                f = (b & c) | (~b & d);
            end else if (sif.rnd < 7'h28) begin
                f = b ^ c ^ d;
                kx = 2'h1;
            end else if (sif.rnd < 7'h3C) begin
                f = (b & c) | (b & d) | (c & d);
                kx = 2'h2;
            end else begin
                f = b ^ c ^ d;
                kx = 2'h3;
            end
            sum = {a[26:0], a[31:27]} + f + e + mde_pkg::SHA_K[kx] + sif.wrd;
            sif.wk_out = {d, c, {b[1:0], b[31:2]}, a, sum};
        end
    end
endmodule

// ---- rtl/mde_fifo.sv ----
// Input word queue in flip-flops; depth must be a power of two
`timescale 1ns/1ps
module mde_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clr_in,
    input wire logic in_valid_in,
    input wire logic [W-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [W-1:0] out_data_out,
    input wire logic out_ready_in,
    output logic [$clog2(DEPTH):0] count_out
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, rp_r;
    logic [AW:0] cnt_r;
    logic push, pop;
    assign in_ready_out = cnt_r != (AW+1)'(DEPTH);
    assign out_valid_out = cnt_r != '0;
    assign out_data_out = mem_r[rp_r];
    assign count_out = cnt_r;
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (clr_in) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= wp_r + 1'b1;
            if (pop) rp_r <= rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (push) mem_r[wp_r] <= in_data_in;
    end
endmodule

// ---- rtl/mde_top.sv ----
// Message digest engine: SHA-1 / MD5 / HMAC with register port and DMA pacing
`timescale 1ns/1ps
module mde_top (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic dma_req_out,
    output logic irq_out
);
    logic algo_r, hmac_r, dma_en_r, fin_r, outer_r, last_r, lenok_r;
    logic input_ready_flag, digest_done_flag, dma_active_flag;
    logic [1:0] mask_r;
    logic [4:0] nbw_r, widx_r;
    logic [2:0] icnt_r;
    logic [6:0] cyc_r, rnd_r;
    logic [63:0] len_r;
    logic [31:0] rdata_r;
    logic [31:0] blk_r [mde_pkg::BLK_WORDS];
    logic [4:0][31:0] h_r, wk_r, inner_r, h_sum;
    logic [4:0][31:0] chain [3];
    mde_pkg::mde_swap_t swap_r;
    mde_pkg::mde_phase_t phase_r;
    mde_pkg::mde_core_t core_r;

    // Register port decode
    logic wr_ctrl, init_c, wr_din, dig_hit;
    logic [2:0] dig_idx;
    logic [7:0] dig_ofs;
    assign wr_ctrl = wr_in && addr_in == mde_pkg::OFS_CTRL;
    assign init_c = wr_ctrl && wdata_in[mde_pkg::CTL_INIT];
    assign wr_din = wr_in && addr_in == mde_pkg::OFS_DIN;
    assign dig_ofs = addr_in - mde_pkg::OFS_DIG0;
    assign dig_hit = addr_in >= mde_pkg::OFS_DIG0 && dig_ofs < 8'h14 && addr_in[1:0] == 2'h0;
    assign dig_idx = dig_ofs[4:2];

    // Input queue
    logic fifo_rdy, fifo_vld, pop_c, in_phase;
    logic [31:0] fifo_dat;
    logic [4:0] fifo_cnt;
    assign in_phase = phase_r == mde_pkg::PH_KEY_IN || phase_r == mde_pkg::PH_MSG
        || phase_r == mde_pkg::PH_KEY_OUT;
    mde_fifo #(.W(32), .DEPTH(mde_pkg::FIFO_DEPTH)) u_fifo (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clr_in(init_c),
        .in_valid_in(wr_din && in_phase),
        .in_data_in(wdata_in),
        .in_ready_out(fifo_rdy),
        .out_valid_out(fifo_vld),
        .out_data_out(fifo_dat),
        .out_ready_in(pop_c),
        .count_out(fifo_cnt)
    );

    // Writes while full are dropped, so the request must fall first
    assign dma_req_out = dma_en_r && fifo_rdy && in_phase && !fin_r;
    assign dma_active_flag = dma_req_out;

    function automatic logic [31:0] swap_word(input logic [31:0] w, input mde_pkg::mde_swap_t m);
        logic [31:0] r;
        r = w;
        unique case (m)
            mde_pkg::MDE_SW_WORD: r = w;
            mde_pkg::MDE_SW_HALF: r = {w[15:0], w[31:16]};
            mde_pkg::MDE_SW_BYTE: r = {w[7:0], w[15:8], w[23:16], w[31:24]};
            mde_pkg::MDE_SW_BIT: for (int i = 0; i < 32; i++) r[i] = w[31-i];
        endcase
        return r;
    endfunction

    // Keep n message bits, append the one bit; MD5 orders bytes from the low end
    function automatic logic [31:0] pad_word(input logic [31:0] w, input logic [5:0] n,
                                             input logic md5);
        logic [31:0] r;
        int p;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            p = md5 ? (i / 8) * 8 + 7 - (i % 8) : 31 - i;
            if (i < int'(n)) r[p] = w[p];
            else if (i == int'(n)) r[p] = 1'b1;
        end
        return r;
    endfunction

    function automatic logic [3:0] md5_idx(input logic [6:0] r);
        logic [3:0] i;
        i = r[3:0];
        unique case (r[5:4])
            2'h0: md5_idx = i;
            2'h1: md5_idx = 4'(i * 5 + 1);
            2'h2: md5_idx = 4'(i * 3 + 5);
            2'h3: md5_idx = 4'(i * 7);
        endcase
    endfunction

    // Block builder: picks the next word for the block buffer
    logic take_c, pad_c;
    logic [31:0] word_c, fw;
    logic [5:0] add_c;
    logic [2:0] dig_n;
    assign dig_n = algo_r ? 3'h4 : 3'h5;
    assign fw = swap_word(fifo_dat, swap_r);
    always_comb begin
        take_c = 1'b0;
        pop_c = 1'b0;
        pad_c = 1'b0;
        word_c = '0;
        add_c = 6'h00;
        if (core_r == mde_pkg::CORE_IDLE && !widx_r[4]) begin
            unique case (phase_r)
                mde_pkg::PH_KEY_IN, mde_pkg::PH_KEY_OUT: begin
                    if (fifo_vld) begin
                        take_c = 1'b1;
                        pop_c = 1'b1;
                        add_c = 6'h20;
                        word_c = fw ^ (phase_r == mde_pkg::PH_KEY_IN ? mde_pkg::IPAD
                            : mde_pkg::OPAD);
                    end
                end
                mde_pkg::PH_MSG: begin
                    // Last queued word waits for the finish, which may cut it short
                    if (fifo_vld && (fin_r || fifo_cnt != 5'h01)) begin
                        take_c = 1'b1;
                        pop_c = 1'b1;
                        add_c = 6'h20;
                        word_c = fw;
                        if (fin_r && fifo_cnt == 5'h01 && nbw_r != 5'h00) begin
                            word_c = pad_word(fw, {1'b0, nbw_r}, algo_r);
                            add_c = {1'b0, nbw_r};
                            pad_c = 1'b1;
                        end
                    end else if (fin_r) begin
                        take_c = 1'b1;
                        word_c = pad_word('0, 6'h00, algo_r);
                        pad_c = 1'b1;
                    end
                end
                mde_pkg::PH_INNER: begin
                    take_c = 1'b1;
                    if (icnt_r < dig_n) begin
                        word_c = inner_r[icnt_r];
                        add_c = 6'h20;
                    end else begin
                        word_c = pad_word('0, 6'h00, algo_r);
                        pad_c = 1'b1;
                    end
                end
                mde_pkg::PH_TAIL: begin
                    take_c = 1'b1;
                    // Length fills the last two words; word order differs per hash
                    if (lenok_r && widx_r == 5'h0E) word_c = algo_r ? len_r[31:0] : len_r[63:32];
                    else if (lenok_r && widx_r == 5'h0F)
                        word_c = algo_r ? len_r[63:32] : len_r[31:0];
                end
                mde_pkg::PH_IDLE, mde_pkg::PH_DONE: ;
            endcase
        end
    end

    // Core control
    logic core_start, core_done, hmac_turn;
    logic [6:0] cyc_total, rnd_total;
    assign core_start = core_r == mde_pkg::CORE_IDLE && widx_r[4];
    assign cyc_total = algo_r ? mde_pkg::MD5_BLOCK_CYC : mde_pkg::SHA1_BLOCK_CYC;
    assign rnd_total = algo_r ? mde_pkg::MD5_ROUNDS : mde_pkg::SHA1_ROUNDS;
    assign core_done = core_r == mde_pkg::CORE_RUN && cyc_r == cyc_total;
    assign hmac_turn = core_done && last_r && hmac_r && !outer_r;

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            widx_r <= '0;
            len_r <= '0;
            phase_r <= mde_pkg::PH_IDLE;
            lenok_r <= 1'b0;
            icnt_r <= '0;
            outer_r <= 1'b0;
            inner_r <= '0;
        end else if (init_c) begin
            widx_r <= '0;
            len_r <= '0;
            phase_r <= wdata_in[mde_pkg::CTL_HMAC] ? mde_pkg::PH_KEY_IN : mde_pkg::PH_MSG;
            lenok_r <= 1'b0;
            icnt_r <= '0;
            outer_r <= 1'b0;
        end else begin
            if (take_c) begin
                widx_r <= widx_r + 5'h01;
                len_r <= len_r + 64'(add_c);
                if (pad_c) begin
                    phase_r <= mde_pkg::PH_TAIL;
                    lenok_r <= widx_r < 5'h0E;
                end
                if (phase_r == mde_pkg::PH_INNER && icnt_r < dig_n) icnt_r <= icnt_r + 3'h1;
            end
            if (core_start) begin
                widx_r <= '0;
                if (phase_r == mde_pkg::PH_TAIL) lenok_r <= 1'b1;
                if (phase_r == mde_pkg::PH_KEY_IN) phase_r <= mde_pkg::PH_MSG;
                if (phase_r == mde_pkg::PH_KEY_OUT) phase_r <= mde_pkg::PH_INNER;
            end
            if (hmac_turn) begin
                // Second pass over the outer key and the inner digest
                inner_r <= h_sum;
                phase_r <= mde_pkg::PH_KEY_OUT;
                outer_r <= 1'b1;
                len_r <= '0;
                lenok_r <= 1'b0;
                icnt_r <= '0;
            end else if (core_done && last_r) begin
                phase_r <= mde_pkg::PH_DONE;
            end
        end
    end

    // Block buffer; SHA-1 slides it as a 16-word schedule window
    logic [31:0] nw0, nw1, x0, x1;
    assign x0 = blk_r[13] ^ blk_r[8] ^ blk_r[2] ^ blk_r[0];
    assign x1 = blk_r[14] ^ blk_r[9] ^ blk_r[3] ^ blk_r[1];
    assign nw0 = {x0[30:0], x0[31]};
    assign nw1 = {x1[30:0], x1[31]};
    always_ff @(posedge clk_sys_in) begin
        if (take_c) begin
            blk_r[widx_r[3:0]] <= word_c;
        end else if (core_r == mde_pkg::CORE_RUN && !algo_r && rnd_r < rnd_total) begin
            for (int i = 0; i < 14; i++) blk_r[i] <= blk_r[i+2];
            blk_r[14] <= nw0;
            blk_r[15] <= nw1;
        end
    end

    // Two round steps per cycle; the rest of the block time is padding
    assign chain[0] = wk_r;
    for (genvar g = 0; g < 2; g++) begin : g_step
        mde_step_if sif ();
        logic [6:0] rg;
        assign rg = rnd_r + 7'(g);
        assign sif.wk_in = chain[g];
        assign sif.rnd = rg;
        assign sif.md5 = algo_r;
        assign sif.wrd = algo_r ? blk_r[md5_idx(rg)] : blk_r[g];
        assign chain[g+1] = sif.wk_out;
        mde_step u_step (
            .sif(sif.step)
        );
    end

    for (genvar i = 0; i < mde_pkg::DIG_WORDS; i++) begin : g_sum
        // MD5 has only four state words; the fifth stays put
        assign h_sum[i] = (algo_r && i == 4) ? h_r[i] : h_r[i] + wk_r[i];
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            core_r <= mde_pkg::CORE_IDLE;
            cyc_r <= '0;
            rnd_r <= '0;
            wk_r <= '0;
            last_r <= 1'b0;
            h_r <= '0;
        end else if (init_c) begin
            core_r <= mde_pkg::CORE_IDLE;
            last_r <= 1'b0;
            for (int i = 0; i < mde_pkg::DIG_WORDS; i++) h_r[i] <= mde_pkg::H_INIT[i];
        end else if (wr_in && dig_hit && core_r == mde_pkg::CORE_IDLE) begin
            h_r[dig_idx] <= wdata_in;
        end else begin
            unique case (core_r)
                mde_pkg::CORE_IDLE: begin
                    if (core_start) begin
                        core_r <= mde_pkg::CORE_RUN;
                        cyc_r <= 7'h01;
                        rnd_r <= '0;
                        wk_r <= h_r;
                        last_r <= phase_r == mde_pkg::PH_TAIL && lenok_r;
                    end
                end
                mde_pkg::CORE_RUN: begin
                    cyc_r <= cyc_r + 7'h01;
                    if (rnd_r < rnd_total) begin
                        wk_r <= chain[2];
                        rnd_r <= rnd_r + 7'h02;
                    end
                    if (core_done) begin
                        core_r <= mde_pkg::CORE_IDLE;
                        if (hmac_turn) begin
                            for (int i = 0; i < mde_pkg::DIG_WORDS; i++)
                                h_r[i] <= mde_pkg::H_INIT[i];
                        end else begin
                            h_r <= h_sum;
                        end
                    end
                end
            endcase
        end
    end

    // Control, finish and mask registers
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            algo_r <= 1'b0;
            hmac_r <= 1'b0;
            dma_en_r <= 1'b0;
            swap_r <= mde_pkg::MDE_SW_WORD;
            nbw_r <= '0;
            fin_r <= 1'b0;
            mask_r <= mde_pkg::MASK_RST;
        end else begin
            if (wr_ctrl) begin
                algo_r <= wdata_in[mde_pkg::CTL_ALGO];
                hmac_r <= wdata_in[mde_pkg::CTL_HMAC];
                swap_r <= mde_pkg::mde_swap_t'(wdata_in[mde_pkg::CTL_SWAP +: 2]);
                dma_en_r <= wdata_in[mde_pkg::CTL_DMA];
            end
            if (init_c || pad_c) fin_r <= 1'b0;
            else if (wr_in && addr_in == mde_pkg::OFS_FIN && wdata_in[mde_pkg::FIN_GO]) begin
                fin_r <= 1'b1;
                nbw_r <= wdata_in[4:0];
            end
            if (wr_in && addr_in == mde_pkg::OFS_MASK) mask_r <= wdata_in[1:0];
        end
    end

    // Sticky flags: a new event beats a write-one clear
    logic ev_inrdy, ev_done, clr_stat;
    assign ev_inrdy = core_done && in_phase;
    assign ev_done = core_done && last_r && !hmac_turn;
    assign clr_stat = wr_in && addr_in == mde_pkg::OFS_STAT;
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            input_ready_flag <= 1'b0;
            digest_done_flag <= 1'b0;
        end else begin
            if (ev_inrdy) input_ready_flag <= 1'b1;
            else if (clr_stat && wdata_in[mde_pkg::STS_INRDY]) input_ready_flag <= 1'b0;
            if (ev_done) digest_done_flag <= 1'b1;
            else if (clr_stat && wdata_in[mde_pkg::STS_DONE]) digest_done_flag <= 1'b0;
        end
    end
    assign irq_out = |({digest_done_flag, input_ready_flag} & mask_r);

    // Read port: data valid only in the cycle after the strobe
    logic [31:0] rd_val;
    always_comb begin
        rd_val = '0;
        if (dig_hit) rd_val = h_r[dig_idx];
        else if (addr_in == mde_pkg::OFS_CTRL)
            rd_val = 32'({dma_en_r, swap_r, hmac_r, algo_r, 1'b0});
        else if (addr_in == mde_pkg::OFS_FIN) rd_val = 32'({fin_r, 3'h0, nbw_r});
        else if (addr_in == mde_pkg::OFS_STAT)
            rd_val = 32'({core_r == mde_pkg::CORE_RUN, dma_active_flag, digest_done_flag,
                input_ready_flag});
        else if (addr_in == mde_pkg::OFS_MASK) rd_val = 32'(mask_r);
    end
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) rdata_r <= '0;
        else rdata_r <= rd_in ? rd_val : '0;
    end
    assign rdata_out = rdata_r;
endmodule

// ---- tb/mde_checker.sv ----
// Port-level assertions for the digest engine
`timescale 1ns/1ps
module mde_checker (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic dma_req_out,
    input wire logic irq_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    a_read_idle_zero: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data not zero outside a read");
    a_mask_off_quiet: assert property (wr_in && addr_in == mde_pkg::OFS_MASK &&
        wdata_in[1:0] == 2'h0 |=> !irq_out) else $error("interrupt with mask cleared");
    a_dma_flag_mirror: assert property (rd_in && addr_in == mde_pkg::OFS_STAT |=>
        rdata_out[mde_pkg::STS_DMA] == $past(dma_req_out)) else $error("dma flag mismatch");
    a_dma_off_idle: assert property (wr_in && addr_in == mde_pkg::OFS_CTRL &&
        !wdata_in[mde_pkg::CTL_DMA] |=> !dma_req_out) else $error("request while disabled");
    a_unmapped_zero: assert property (rd_in && addr_in > 8'h24 |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_init_zero: assert property (rd_in && addr_in == mde_pkg::OFS_CTRL |=>
        !rdata_out[mde_pkg::CTL_INIT]) else $error("init bit reads back");
    a_reset_quiet: assert property ($fell(sys_rst_in) |-> !dma_req_out && !irq_out)
        else $error("outputs active after reset");
    a_din_read_zero: assert property (rd_in && addr_in == mde_pkg::OFS_DIN |=>
        rdata_out == 32'h0) else $error("input port reads nonzero");
endmodule

bind mde_top mde_checker chk_u (.clk_sys_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .dma_req_out, .irq_out);

// ---- tb/mde_dma_model.sv ----
// DMA controller stand-in: one input word per go pulse
`timescale 1ns/1ps
module mde_dma_model (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic req_in,
    input wire logic go_in,
    input wire logic [31:0] word_in,
    output logic wr_out,
    output logic [31:0] wdata_out,
    output logic done_out
);
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_out <= 1'b0;
            wdata_out <= 32'h0;
            done_out <= 1'b0;
        end else if (go_in && req_in && !wr_out && !done_out) begin
            wr_out <= 1'b1;
            wdata_out <= word_in;
            done_out <= 1'b1;
        end else begin
            wr_out <= 1'b0;
            // Released data toggles so a stale word is never mistaken for live
            wdata_out <= ~wdata_out;
            done_out <= done_out && go_in;
        end
    end
endmodule

// ---- tb/mde_top_tb_top.sv ----
// Self-checking bench for the digest engine
`timescale 1ns/1ps
module mde_top_tb_top;
    logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, b_wr = 1'b0, rd_in = 1'b0, go = 1'b0;
    logic [7:0] b_addr = 8'h00;
    logic [31:0] b_wdata = 32'h0, rdata_out, dm_wdata, v;
    logic dma_req_out, irq_out, dm_wr, dm_done;
    int n_errors = 0, compares = 0, n;
    mde_top dut_u (.clk_sys_in, .sys_rst_in, .addr_in(dm_wr ? mde_pkg::OFS_DIN : b_addr),
        .wdata_in(dm_wr ? dm_wdata : b_wdata), .wr_in(b_wr | dm_wr), .rd_in, .rdata_out,
        .dma_req_out, .irq_out);
    mde_dma_model dma_u (.clk_sys_in, .sys_rst_in, .req_in(dma_req_out), .go_in(go),
        .word_in(32'h61626300), .wr_out(dm_wr), .wdata_out(dm_wdata), .done_out(dm_done));
    initial begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        b_wr <= 1'b1;
        b_addr <= a;
        b_wdata <= d;
        @(posedge clk_sys_in);
        b_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in);
        rd_in <= 1'b1;
        b_addr <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, exp);
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Status read every cycle, so the busy count is exact
    task automatic busy_run(input int exp);
        n = 0;
        @(posedge clk_sys_in);
        rd_in <= 1'b1;
        b_addr <= mde_pkg::OFS_STAT;
        for (int i = 0; i < 150; i++) begin
            @(posedge clk_sys_in);
            #1 v = rdata_out;
            n += int'(v[mde_pkg::STS_BUSY]);
        end
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        chk(32'(n), 32'(exp));
        chk(v & 32'hA, 32'h2);
    endtask
    task automatic t_reset();
        chk({30'h0, dma_req_out, irq_out}, 32'h0);
        rd(mde_pkg::OFS_MASK, 32'h0);
        rd(8'h40, 32'h0);
        rd(mde_pkg::OFS_DIN, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_sha_dma();
        wr(mde_pkg::OFS_CTRL, 32'h21);
        rd(mde_pkg::OFS_STAT, 32'h4);
        go <= 1'b1;
        for (int i = 0; i < 100 && !dm_done; i++) @(posedge clk_sys_in);
        if (!dm_done) begin
            n_errors++;
            conclude();
        end
        go <= 1'b0;
        wr(mde_pkg::OFS_FIN, 32'h118);
        busy_run(66);
        rd(mde_pkg::OFS_DIG0, 32'hA9993E36);
        rd(mde_pkg::OFS_DIG0 + 8'h10, 32'h9CD0D89D);
        $display("sha dma test done");
    endtask
    task automatic t_md5_swap(input logic [31:0] ctl, input logic [31:0] w);
        wr(mde_pkg::OFS_CTRL, ctl);
        rd(mde_pkg::OFS_CTRL, ctl & 32'h3E);
        wr(mde_pkg::OFS_DIN, w);
        wr(mde_pkg::OFS_FIN, 32'h118);
        busy_run(50);
        rd(mde_pkg::OFS_DIG0, 32'h98500190);
        $display("md5 swap test done");
    endtask
    task automatic t_irq();
        wr(mde_pkg::OFS_MASK, 32'h0);
        chk({31'h0, irq_out}, 32'h0);
        wr(mde_pkg::OFS_MASK, 32'h2);
        chk({31'h0, irq_out}, 32'h1);
        wr(mde_pkg::OFS_STAT, 32'h3);
        chk({31'h0, irq_out}, 32'h0);
        rd(mde_pkg::OFS_STAT, 32'h0);
        $display("interrupt test done");
    endtask
    // Keyed SHA-1 of a short message; key block written again for the outer pass
    task automatic t_hmac();
        logic [223:0] m = {32'h77686174, 32'h20646F20, 32'h79612077, 32'h616E7420,
            32'h666F7220, 32'h6E6F7468, 32'h696E673F};
        wr(mde_pkg::OFS_CTRL, 32'h25);
        for (int i = 0; i < 16; i++) wr(mde_pkg::OFS_DIN, i == 0 ? 32'h4A656665 : 32'h0);
        for (int i = 0; i < 7; i++) wr(mde_pkg::OFS_DIN, m[223-32*i-:32]);
        wr(mde_pkg::OFS_FIN, 32'h100);
        for (n = 0; n < 400 && !dma_req_out; n++) begin
            @(posedge clk_sys_in);
            #1;
        end
        chk({31'h0, dma_req_out}, 32'h1);
        for (int i = 0; i < 16; i++) wr(mde_pkg::OFS_DIN, i == 0 ? 32'h4A656665 : 32'h0);
        for (n = 0; n < 400 && !irq_out; n++) begin
            @(posedge clk_sys_in);
            #1;
        end
        chk({31'h0, irq_out}, 32'h1);
        rd(mde_pkg::OFS_DIG0, 32'hEFFCDF6A);
        rd(mde_pkg::OFS_DIG0 + 8'h10, 32'h259A7C79);
        $display("hmac test done");
    endtask
    task automatic t_resume();
        for (int i = 0; i < 5; i++) wr(mde_pkg::OFS_DIG0 + 8'(4 * i), 32'hC0DE0000 + 32'(i));
        for (int i = 0; i < 5; i++) rd(mde_pkg::OFS_DIG0 + 8'(4 * i), 32'hC0DE0000 + 32'(i));
        $display("resume test done");
    endtask
    initial begin
        repeat (16) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_sha_dma();
        t_md5_swap(32'h0B, 32'h62610063);
        t_md5_swap(32'h13, 32'h61626300);
        t_md5_swap(32'h1B, 32'h8646C600);
        t_irq();
        t_hmac();
        t_resume();
        conclude();
    end
endmodule
